//--- hdl/energy_det_consts.svh
// Constants for the receive energy detection block
`ifndef ENERGY_DET_CONSTS_SVH
`define ENERGY_DET_CONSTS_SVH
`define ED_MODE_AUTO     2'h0
`define ED_MODE_SINGLE   2'h1
`define ED_MODE_CONT     2'h2
`define ED_MODE_OFF      2'h3
`define ED_INVALID       8'h7f
`define ED_CLK_MHZ       125
`define ED_SETTLE_NS     8000
`define ED_TB0_US        2
`define ED_TB1_US        8
`define ED_TB2_US        32
`define ED_TB3_US        128
`endif

//--- hdl/energy_det_pkg.sv
// Types for the receive energy detection block
package energy_det_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_AVG,
        ST_DONE
    } meas_state_t;
endpackage

//--- hdl/rx_energy_detection.sv
// Receive power reading and energy averaging logic
`timescale 1ns/1ps
`include "energy_det_consts.svh"

module rx_energy_detection #(
    parameter int SETTLE_CYC = (`ED_SETTLE_NS * `ED_CLK_MHZ) / 1000,
    parameter int TB_US_CYC  = `ED_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Receiver status and gain loop
    input  wire logic        rx_state,
    input  wire logic [3:0]  rx_sample_rate_sel,
    input  wire logic [15:0] gain_update_cycles,
    input  wire logic        power_sample_valid,
    input  wire logic [7:0]  power_sample,
    // Baseband
    input  wire logic        baseband_enable_bit,
    input  wire logic        bb_gain_hold,
    input  wire logic        bb_frame_cancel,
    input  wire logic        frame_rx_start_irq,
    // Software controls
    input  wire logic        gain_hold_control,
    input  wire logic        mode_wr,
    input  wire logic [1:0]  mode_wdata,
    input  wire logic [7:0]  energy_window_config,
    // Results
    output logic      [7:0]  rx_power_reading,
    output logic      [1:0]  energy_mode_field,
    output logic      [7:0]  energy_result,
    output logic             energy_done_irq,
    output logic             meas_busy
);
    // ********************************************************
    // Reset release and input synchronisers
    // ********************************************************
    logic rst_s1_r, rst_n;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    logic [1:0] rx_sy_r, hold_sy_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sy_r   <= 2'h0;
            hold_sy_r <= 2'h0;
        end else begin
            rx_sy_r   <= {rx_sy_r[0], rx_state};
            hold_sy_r <= {hold_sy_r[0], gain_hold_control};
        end
    end
    wire rx_on   = rx_sy_r[1];
    wire sw_hold = hold_sy_r[1];

    // ********************************************************
    // Power reading validity
    // ********************************************************
    logic [31:0] settle_cnt_r;
    logic        rssi_ok_r;
    wire  [31:0] settle_need = SETTLE_CYC * rx_sample_rate_sel
                               + {16'h0, gain_update_cycles};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt_r <= 32'h0;
            rssi_ok_r    <= 1'b0;
        end else if (!rx_on) begin
            settle_cnt_r <= 32'h0;
            rssi_ok_r    <= 1'b0;
        end else if (settle_cnt_r >= settle_need) begin
            rssi_ok_r <= 1'b1;
        end else begin
            settle_cnt_r <= settle_cnt_r + 32'h1;
        end
    end
    wire sample_ok = rssi_ok_r && power_sample_valid;

    // reading follows estimates regardless of gain hold
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            rx_power_reading <= `ED_INVALID;
        else if (!rssi_ok_r)
            rx_power_reading <= `ED_INVALID;
        else if (power_sample_valid)
            rx_power_reading <= power_sample;
    end

    // ********************************************************
    // Window timing
    // ********************************************************
    wire [5:0]  window_factor    = energy_window_config[7:2];
    wire [1:0]  window_time_base = energy_window_config[1:0];
    wire [7:0]  base_us = (window_time_base == 2'h0) ? 8'(`ED_TB0_US) :
                          (window_time_base == 2'h1) ? 8'(`ED_TB1_US) :
                          (window_time_base == 2'h2) ? 8'(`ED_TB2_US) :
                                                       8'(`ED_TB3_US);
    wire [13:0] window_us = 14'(window_factor) * 14'(base_us);

    logic [7:0]  us_div_r;
    logic [13:0] us_cnt_r;
    wire         us_tick = (us_div_r == 8'(TB_US_CYC - 1));

    // ********************************************************
    // Measurement control
    // ********************************************************
    energy_det_pkg::meas_state_t st_r, st_nxt;
    logic        auto_run_r;
    logic        hold_d_r;
    logic        cont_again_r;
    logic signed [21:0] acc_r;
    logic [13:0] n_r;

    wire hold_any  = (baseband_enable_bit && bb_gain_hold) || sw_hold;
    wire hold_rise = hold_any && !hold_d_r;
    wire can_run   = rx_on && energy_mode_field != `ED_MODE_OFF;
    wire auto_go   = can_run && energy_mode_field == `ED_MODE_AUTO
                     && hold_rise;
    wire man_go    = rx_on && mode_wr && (mode_wdata == `ED_MODE_SINGLE
                     || mode_wdata == `ED_MODE_CONT);
    // automatic run aborts on cancel, hold release or receive left; manual run on receive left or an automatic mode write
    wire auto_abort = auto_run_r && (bb_frame_cancel || !rx_on
                      || !hold_any);
    wire man_abort  = !auto_run_r && (!rx_on || (mode_wr
                      && mode_wdata == `ED_MODE_AUTO));
    wire win_end   = st_r == energy_det_pkg::ST_AVG && us_tick
                     && (us_cnt_r + 14'h1 >= window_us);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            energy_det_pkg::ST_IDLE:
                if (auto_go || man_go)
                    st_nxt = energy_det_pkg::ST_AVG;
            energy_det_pkg::ST_AVG:
                if (auto_abort || man_abort)
                    st_nxt = energy_det_pkg::ST_IDLE;
                else if (win_end)
                    st_nxt = energy_det_pkg::ST_DONE;
            energy_det_pkg::ST_DONE:
                if (cont_again_r && rx_on && !mode_wr
                    && energy_mode_field == `ED_MODE_CONT)
                    st_nxt = energy_det_pkg::ST_AVG;
                else
                    st_nxt = energy_det_pkg::ST_IDLE;
        endcase
    end

    // window restarts each period from config
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            us_div_r <= 8'h0;
            us_cnt_r <= 14'h0;
        end else if (st_r != energy_det_pkg::ST_AVG) begin
            us_div_r <= 8'h0;
            us_cnt_r <= 14'h0;
        end else if (us_tick) begin
            us_div_r <= 8'h0;
            us_cnt_r <= us_cnt_r + 14'h1;
        end else begin
            us_div_r <= us_div_r + 8'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= 22'sh0;
            n_r   <= 14'h0;
        end else if (st_r != energy_det_pkg::ST_AVG) begin
            acc_r <= 22'sh0;
            n_r   <= 14'h0;
        end else if (sample_ok) begin
            acc_r <= acc_r + 22'(signed'(power_sample));
            n_r   <= n_r + 14'h1;
        end
    end

    // rounded mean (half added toward the sign)
    wire signed [22:0] half  = 23'(signed'({1'b0, n_r[13:1]}));
    wire signed [22:0] acc_x = 23'(acc_r);
    wire signed [22:0] rnd   = acc_r[21] ? acc_x - half : acc_x + half;
    wire signed [22:0] mean  = rnd / signed'({9'h0, n_r});
    // mean of in-range inputs stays in -127..4
    wire [7:0] mean8 = (n_r == 14'h0) ? `ED_INVALID : mean[7:0];

    // Completion as seen in the cycle the window closes
    wire done_now = st_r == energy_det_pkg::ST_AVG && st_nxt
                    == energy_det_pkg::ST_DONE;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r       <= energy_det_pkg::ST_IDLE;
            auto_run_r <= 1'b0;
            hold_d_r   <= 1'b0;
            meas_busy  <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            hold_d_r <= hold_any;
            meas_busy <= st_nxt == energy_det_pkg::ST_AVG;
            // Kept after the run so a frame start can clear its result
            if (st_r == energy_det_pkg::ST_IDLE && (auto_go || man_go))
                auto_run_r <= auto_go && !man_go;
        end
    end

    // ********************************************************
    // Mode field, result and done pulse
    // ********************************************************
    // automatic after reset
    // continuous left by receive exit returns to automatic
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            energy_mode_field <= `ED_MODE_AUTO;
        else if (mode_wr)
            energy_mode_field <= mode_wdata;
        else if (done_now && energy_mode_field == `ED_MODE_SINGLE)
            energy_mode_field <= `ED_MODE_AUTO;
        else if (!rx_on && energy_mode_field == `ED_MODE_CONT)
            energy_mode_field <= `ED_MODE_AUTO;
    end

    // auto result held until frame start, 127 on abort
    // manual result held until the next completion or a later auto run's abort or frame start
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            energy_result <= `ED_INVALID;
        else if (done_now)
            energy_result <= mean8;
        else if (st_r == energy_det_pkg::ST_AVG && auto_abort)
            energy_result <= `ED_INVALID;
        else if (frame_rx_start_irq && auto_run_r)
            energy_result <= `ED_INVALID;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            energy_done_irq <= 1'b0;
            cont_again_r    <= 1'b0;
        end else begin
            energy_done_irq <= done_now && !auto_run_r;
            cont_again_r    <= done_now && !auto_run_r && rx_on
                               && energy_mode_field == `ED_MODE_CONT;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    no_auto_irq_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (done_now && auto_run_r) |=> !energy_done_irq)
        else $error("automatic completion pulsed done");
    idle_outside_rx_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !rx_on |=> st_r != energy_det_pkg::ST_AVG)
        else $error("measurement running outside receive");
    invalid_reading_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !rssi_ok_r |=> rx_power_reading == `ED_INVALID)
        else $error("reading not invalid before settle");
    single_back_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (done_now && !mode_wr && energy_mode_field == `ED_MODE_SINGLE)
        |=> energy_mode_field == `ED_MODE_AUTO && energy_done_irq)
        else $error("single did not return to automatic");
    auto_abort_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (st_r == energy_det_pkg::ST_AVG && auto_abort)
        |=> energy_result == `ED_INVALID)
        else $error("aborted automatic run kept a result");
    off_blocks_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (st_r == energy_det_pkg::ST_IDLE && !mode_wr
         && energy_mode_field == `ED_MODE_OFF)
        |=> st_r == energy_det_pkg::ST_IDLE)
        else $error("measurement started while disabled");
    manual_done_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (done_now && !auto_run_r)
        |=> energy_done_irq && energy_result == $past(mean8))
        else $error("manual completion lost pulse or result");
endmodule

//--- dv/gain_loop_model.sv
// Gain loop model feeding periodic power estimates
`timescale 1ns/1ps
module gain_loop_model #(
    parameter int PERIOD = 4
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Level the bench wants reported
    input  wire logic [7:0] level,
    // Estimate stream
    output logic            power_sample_valid,
    output logic      [7:0] power_sample
);
    int cnt;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt                <= 0;
            power_sample_valid <= 1'b0;
            power_sample       <= 8'h00;
        end else begin
            cnt                <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            power_sample_valid <= (cnt == PERIOD - 1);
            // Data alternates between the inverted and a stale copy between strobes
            power_sample <= (cnt == PERIOD - 1) ? level : ~power_sample;
        end
    end
endmodule

//--- dv/rx_energy_detection_tb.sv
// Self-checking bench for receive energy detection
`timescale 1ns/1ps
`include "energy_det_consts.svh"
module rx_energy_detection_tb;
    localparam int US = 4;
    logic       core_clk = 1'b0, resetn = 1'b0, rx_state = 1'b0;
    logic       baseband_enable_bit = 1'b0, bb_gain_hold = 1'b0;
    logic       bb_frame_cancel = 1'b0, frame_rx_start_irq = 1'b0;
    logic       gain_hold_control = 1'b0, mode_wr = 1'b0;
    logic [1:0] mode_wdata = 2'h0;
    logic [7:0] energy_window_config = 8'h08, level = 8'hc0;
    logic       power_sample_valid, energy_done_irq, meas_busy;
    logic [7:0] power_sample, rx_power_reading, energy_result;
    logic [1:0] energy_mode_field;
    logic [31:0] seed = 32'hfb07e298;
    int         num_errors = 0, samples_checked = 0, irqs = 0;

    gain_loop_model i_gain_loop_model (.core_clk(core_clk),
        .resetn(resetn), .level(level),
        .power_sample_valid(power_sample_valid),
        .power_sample(power_sample));
    rx_energy_detection #(.SETTLE_CYC(20), .TB_US_CYC(US))
        i_rx_energy_detection (.core_clk(core_clk), .resetn(resetn),
        .rx_state(rx_state), .rx_sample_rate_sel(4'h1),
        .gain_update_cycles(16'h000a),
        .power_sample_valid(power_sample_valid),
        .power_sample(power_sample),
        .baseband_enable_bit(baseband_enable_bit),
        .bb_gain_hold(bb_gain_hold), .bb_frame_cancel(bb_frame_cancel),
        .frame_rx_start_irq(frame_rx_start_irq),
        .gain_hold_control(gain_hold_control), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata),
        .energy_window_config(energy_window_config),
        .rx_power_reading(rx_power_reading),
        .energy_mode_field(energy_mode_field),
        .energy_result(energy_result),
        .energy_done_irq(energy_done_irq), .meas_busy(meas_busy));

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) if (energy_done_irq === 1'b1) irqs++;

    // ********************************************************
    // Helpers
    // ********************************************************
    // Xorshift, mapped onto the legal span -127..4 dBm
    function automatic logic [7:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return 8'h81 + 8'(seed % 132);
    endfunction
    function automatic int win_cyc(input logic [7:0] cfg);
        return int'(cfg[7:2]) * (2 << (2 * cfg[1:0])) * US;
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic new_level();
        @(posedge core_clk);
        level <= xorshift();
    endtask
    task automatic wmode(input logic [1:0] m);
        @(posedge core_clk);
        mode_wr    <= 1'b1;
        mode_wdata <= m;
        @(posedge core_clk);
        mode_wr <= 1'b0;
    endtask
    // Bounded wait so a missing pulse cannot hang the run
    task automatic wirq(input int lim, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (energy_done_irq !== 1'b1 && n < lim);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ********************************************************
    // Tests
    // ********************************************************
    initial begin
        cyc(8000);
        num_errors++;
        $display("watchdog expired at %0t", $time);
        results();
    end

    initial begin
        int n, w, k;
        cyc(5);
        resetn <= 1'b1;
        cyc(5);
        #1;
        check(rx_power_reading, 8'h7f);
        check({6'h0, energy_mode_field}, 8'h00);
        check(energy_result, 8'h7f);
        new_level();
        rx_state <= 1'b1;
        cyc(8);
        #1;
        check(rx_power_reading, 8'h7f);
        cyc(50);
        #1;
        check(rx_power_reading, level);
        $display("test reset done");
        // baseband kept off for manual runs
        for (k = 0; k < 4; k++) begin
            new_level();
            // every window exceeds the update time
            energy_window_config <= {(k == 0) ? 6'h3f : 6'h01, 2'(k)};
            cyc(12);
            w = win_cyc(energy_window_config);
            wmode(`ED_MODE_SINGLE);
            #1;
            check({7'h0, meas_busy}, 8'h01);
            wirq(w + 8, n);
            check({7'h0, n >= w - 3 && n <= w + 3}, 8'h01);
            check(energy_result, level);
            check({6'h0, energy_mode_field}, 8'h00);
            cyc(1);
            #1;
            check({7'h0, energy_done_irq}, 8'h00);
        end
        $display("test single done");
        @(posedge core_clk);
        rx_state <= 1'b0;
        cyc(6);
        wmode(`ED_MODE_SINGLE);
        wirq(w + 8, n);
        check({7'h0, energy_done_irq}, 8'h00);
        check(rx_power_reading, 8'h7f);
        wmode(`ED_MODE_AUTO);
        rx_state <= 1'b1;
        energy_window_config <= 8'h08;
        $display("test idle done");
        cyc(60);
        wmode(`ED_MODE_CONT);
        wirq(40, n);
        new_level();
        wirq(40, n);
        wirq(40, n);
        check({7'h0, energy_done_irq}, 8'h01);
        check(energy_result, level);
        check({6'h0, energy_mode_field}, 8'h02);
        wmode(`ED_MODE_AUTO);
        cyc(3);
        k = irqs;
        cyc(50);
        check(8'(irqs - k), 8'h00);
        wmode(`ED_MODE_CONT);
        cyc(5);
        rx_state <= 1'b0;
        cyc(6);
        #1;
        check({6'h0, energy_mode_field}, 8'h00);
        $display("test continuous done");
        @(posedge core_clk);
        rx_state <= 1'b1;
        baseband_enable_bit <= 1'b1;
        new_level();
        cyc(60);
        k = irqs;
        bb_gain_hold <= 1'b1;
        cyc(30);
        #1;
        check(energy_result, level);
        check(8'(irqs - k), 8'h00);
        cyc(20);
        #1;
        check(energy_result, level);
        cyc(1);
        bb_gain_hold <= 1'b0;
        new_level();
        cyc(4);
        bb_gain_hold <= 1'b1;
        cyc(6);
        bb_frame_cancel <= 1'b1;
        cyc(1);
        bb_frame_cancel <= 1'b0;
        cyc(30);
        #1;
        check(energy_result, 8'h7f);
        cyc(1);
        bb_gain_hold <= 1'b0;
        frame_rx_start_irq <= 1'b1;
        cyc(1);
        frame_rx_start_irq <= 1'b0;
        wmode(`ED_MODE_OFF);
        bb_gain_hold <= 1'b1;
        cyc(4);
        #1;
        check({7'h0, meas_busy}, 8'h00);
        cyc(1);
        bb_gain_hold <= 1'b0;
        baseband_enable_bit <= 1'b0;
        wmode(`ED_MODE_AUTO);
        $display("test baseband done");
        new_level();
        cyc(8);
        gain_hold_control <= 1'b1;
        cyc(30);
        #1;
        check(energy_result, level);
        new_level();
        cyc(12);
        #1;
        check(rx_power_reading, level);
        cyc(1);
        gain_hold_control <= 1'b0;
        cyc(6);
        gain_hold_control <= 1'b1;
        cyc(8);
        gain_hold_control <= 1'b0;
        cyc(30);
        #1;
        check(energy_result, 8'h7f);
        new_level();
        cyc(8);
        gain_hold_control <= 1'b1;
        cyc(30);
        #1;
        check(energy_result, level);
        cyc(1);
        frame_rx_start_irq <= 1'b1;
        cyc(1);
        frame_rx_start_irq <= 1'b0;
        gain_hold_control <= 1'b0;
        cyc(2);
        #1;
        check(energy_result, 8'h7f);
        $display("test hold control done");
        results();
    end
endmodule
